// ### arsc_defs.vh
// Constants for the repeat sweep converter control block.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
// Notes on behaviour
// - Convert both inputs in turn, repeat untriggered
// - Conversion clock is source clock, divided by two when halving or the divided source is selected
// - Ten-bit result per sample
// - Start bit set to one begins conversion
// - Sweep done sets interrupt request flag itself
// - First input to result 0, second to 1
// - Open-circuit assist exists, software can disable
`ifndef ARSC_DEFS_VH
`define ARSC_DEFS_VH
`define ARSC_RES_W 10
`define ARSC_RES_RST 10'h000
`define ARSC_CLK_DIV 2'h2
`define ARSC_SAMPLE_TICKS 5'h0B
`define ARSC_STEP_LAST 5'h0A
`define ARSC_DIV_LAST 2'h1
`define ARSC_SEL_FIRST 2'h0
`define ARSC_SEL_SECOND 2'h1
`define ARSC_FLAG_RST 1'h0
`endif

// ### arsc_ctrl.v
// Control of a two-input converter in repeat sweep mode.
// Assumes a sampling core on the same clock that converts the input picked
// by input_select and holds its code while sample_strobe is high; all
// software controls are register bits on the same clock, so none is synchronised.
`timescale 1ns/1ps
`include "arsc_defs.vh"

module arsc_ctrl (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Software controls
   input wire conversion_start_bit,
   input wire clk_source_undivided,
   input wire div_by_two_sel,
   input wire open_assist_en,
   input wire irq_flag_clear,
   // Analog front end
   input wire [9:0] sample_value,
   output wire [1:0] input_select,
   output wire sample_strobe,
   output reg assist_active_q,
   // Results and status
   output wire [9:0] result_register_0,
   output wire [9:0] result_register_1,
   output wire interrupt_request_flag,
   output wire converter_busy
);

   // ----------------------------------------
   // State encoding
   // ----------------------------------------
   // One-hot: idle, converting the first input, converting the second
   localparam S_IDLE = 3'h1;
   localparam S_CH0 = 3'h2;
   localparam S_CH1 = 3'h4;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Conversion clock
   wire div_en;
   wire conv_tick;
   reg [1:0] div_q;
   reg [1:0] div_d;
   // Step timing
   wire cnt_last;
   wire step_done;
   reg [4:0] cnt_q;
   reg [4:0] cnt_d;
   // Sequencer
   reg [2:0] st_q;
   reg [2:0] st_d;
   // Results
   wire [1:0] step_store;
   wire [2*`ARSC_RES_W-1:0] res_flat;
   genvar gi;
   // Status
   wire flag_set;
   reg flag_q;
   reg flag_d;
   reg assist_d;

   // ----------------------------------------
   // Conversion clock enable
   // ----------------------------------------
   // The source is the system clock itself; a halved conversion clock is
   // made as a one-cycle tick every second edge, so no second clock exists
   assign div_en = div_by_two_sel || !clk_source_undivided;

   always @* begin
      div_d = div_q + 2'h1;
      if (div_q == `ARSC_DIV_LAST) begin
         div_d = 2'h0;
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_d;
      end
   end

   // Undivided source with halving off ticks on every edge
   assign conv_tick = div_en ? (div_q == 2'h0) : 1'h1;

   // ----------------------------------------
   // Step counter
   // ----------------------------------------
   // Counts conversion ticks inside one step; held at zero while idle so
   // that every step after a fresh start lasts the full count
   assign cnt_last = (cnt_q == `ARSC_STEP_LAST);
   assign step_done = conv_tick && cnt_last && (st_q != S_IDLE);

   always @* begin
      cnt_d = cnt_q;
      if (st_q == S_IDLE) begin
         cnt_d = 5'h00;
      end else if (step_done) begin
         cnt_d = 5'h00;
      end else if (conv_tick) begin
         cnt_d = cnt_q + 5'h01;
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------
   // Sweep sequencer
   // ----------------------------------------
   // The start bit is read as a level at the end of every step: while it
   // stays high the pair repeats with no new trigger, and once it drops
   // the step in hand is still finished and stored before going idle
   always @* begin
      st_d = st_q;
      case (st_q)
         S_IDLE: begin
            if (conversion_start_bit) begin
               st_d = S_CH0;
            end
         end
         S_CH0: begin
            if (step_done) begin
               st_d = conversion_start_bit ? S_CH1 : S_IDLE;
            end
         end
         S_CH1: begin
            if (step_done) begin
               st_d = conversion_start_bit ? S_CH0 : S_IDLE;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Front end handshake
   // ----------------------------------------
   // Select follows the state; the strobe marks the last tick of a step
   assign input_select = (st_q == S_CH1) ? `ARSC_SEL_SECOND : `ARSC_SEL_FIRST;
   assign sample_strobe = step_done;
   assign converter_busy = (st_q != S_IDLE);
   assign step_store = {step_done && (st_q == S_CH1), step_done && (st_q == S_CH0)};

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   // One register per input; each is overwritten on every pass and keeps
   // its last code once the sweep stops, so a late handler still reads a pair
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_res
         reg [`ARSC_RES_W-1:0] res_q;
         always @(posedge clock) begin
            if (!rst_n) begin
               res_q <= `ARSC_RES_RST;
            end else if (step_store[gi]) begin
               res_q <= sample_value;
            end
         end
         assign res_flat[gi*`ARSC_RES_W +: `ARSC_RES_W] = res_q;
      end
   endgenerate

   assign result_register_0 = res_flat[`ARSC_RES_W-1:0];
   assign result_register_1 = res_flat[2*`ARSC_RES_W-1:`ARSC_RES_W];

   // ----------------------------------------
   // Interrupt request flag
   // ----------------------------------------
   // Set when the second input of a sweep is stored; a clear on the same
   // edge loses, so a finished sweep is never dropped
   assign flag_set = step_store[1];

   always @* begin
      flag_d = flag_q;
      if (irq_flag_clear) begin
         flag_d = 1'h0;
      end
      if (flag_set) begin
         flag_d = 1'h1;
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         flag_q <= `ARSC_FLAG_RST;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign interrupt_request_flag = flag_q;

   // ----------------------------------------
   // Open-circuit assist
   // ----------------------------------------
   // Active only while converting; a low enable keeps it off entirely
   always @* begin
      assist_d = open_assist_en && converter_busy;
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         assist_active_q <= 1'h0;
      end else begin
         assist_active_q <= assist_d;
      end
   end

endmodule

// ### arsc_chk_checker.sv
// Port checker for arsc_ctrl; bound to every instance.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module arsc_chk (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Software controls
   input wire conversion_start_bit,
   input wire irq_flag_clear,
   // Observed outputs
   input wire sample_strobe,
   input wire [1:0] input_select,
   input wire interrupt_request_flag,
   input wire converter_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_set;
      sample_strobe && input_select == 2'h1 |=> interrupt_request_flag;
   endproperty
   a_set: assert property (p_set) else $error("flag missed");
   property p_why;
      $rose(interrupt_request_flag) |-> $past(sample_strobe && input_select[0]);
   endproperty
   a_why: assert property (p_why) else $error("stray flag");
   property p_idle;
      !converter_busy |-> !sample_strobe;
   endproperty
   a_idle: assert property (p_idle) else $error("strobe idle");
   property p_sel;
      input_select <= 2'h1;
   endproperty
   a_sel: assert property (p_sel) else $error("bad select");
   property p_alt;
      sample_strobe && input_select == 2'h0 && conversion_start_bit |=>
         input_select == 2'h1 && converter_busy;
   endproperty
   a_alt: assert property (p_alt) else $error("no second input");
   property p_stop;
      sample_strobe && !conversion_start_bit |=> !converter_busy;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop");
   property p_stick;
      interrupt_request_flag && !irq_flag_clear |=> interrupt_request_flag;
   endproperty
   a_stick: assert property (p_stick) else $error("flag lost");
   property p_clear;
      irq_flag_clear && !(sample_strobe && input_select == 2'h1) |=> !interrupt_request_flag;
   endproperty
   a_clear: assert property (p_clear) else $error("flag kept");
endmodule
bind arsc_ctrl arsc_chk chk (
   .clock(clock),
   .rst_n(rst_n),
   .conversion_start_bit(conversion_start_bit),
   .irq_flag_clear(irq_flag_clear),
   .sample_strobe(sample_strobe),
   .input_select(input_select),
   .interrupt_request_flag(interrupt_request_flag),
   .converter_busy(converter_busy)
);

// ### arsc_front.sv
// Sampling core model; fixed code per input.
`timescale 1ns/1ps
module arsc_front(input wire [1:0] input_select, output wire [9:0] sample_value);
assign sample_value = input_select[0] ? 10'h2AA : 10'h155;
endmodule

// ### tb_top.sv
// Bench for arsc_ctrl with the sampling core model on its far side.
// Assumes the checker is bound in; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
`include "arsc_defs.vh"
module tb_top;
reg clock = 1'h0;
reg rst_n = 1'h0;
reg st = 1'h0;
reg dv = 1'h0;
reg su = 1'h1;
reg oa = 1'h0;
reg clr = 1'h0;
wire [9:0] sv, r0, r1;
wire [1:0] sel;
wire stb, flg, bsy, ast;
integer mismatches = 0, n_tests = 0;
arsc_ctrl uut(.clock(clock), .rst_n(rst_n), .conversion_start_bit(st),
   .clk_source_undivided(su), .div_by_two_sel(dv), .open_assist_en(oa),
   .irq_flag_clear(clr), .sample_value(sv), .input_select(sel), .sample_strobe(stb),
   .assist_active_q(ast), .result_register_0(r0), .result_register_1(r1),
   .interrupt_request_flag(flg), .converter_busy(bsy));
arsc_front fe(.input_select(sel), .sample_value(sv));
initial begin
   forever #5 clock = ~clock;
end
task chk(input [9:0] s, input [9:0] e); begin
   n_tests = n_tests + 1;
   if (s !== e) begin
      mismatches = mismatches + 1;
      $display("Error t=%0t got %h exp %h", $time, s, e);
   end
end endtask
task close_out; begin
   $display("checks %0d mismatches %0d", n_tests, mismatches);
   if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish;
end endtask
// Cycles until the flag shows, 200 at most
task run_wait(output integer n); integer c; begin
   c = 0;
   while (c < 200 && !flg) begin
      #10;
      c = c + 1;
   end
   n = c;
end endtask
// Handler: copy both results, then clear the flag
task service; reg [9:0] c0, c1; begin
   c0 = r0;
   c1 = r1;
   chk(c0, 10'h155);
   chk(c1, 10'h2AA);
   clr = 1'h1;
   #10;
   clr = 1'h0;
   chk(flg, 1'h0);
end endtask
task stop_sweep; begin
   st = 1'h0;
   #500;
   chk(bsy, 1'h0);
   chk(stb, 1'h0);
   chk(sel, 2'h0);
   clr = 1'h1;
   #10;
   clr = 1'h0;
   #300;
   chk(flg, 1'h0);
end endtask
task t_undivided; integer n; begin
   dv = 1'h0;
   su = 1'h1;
   oa = 1'h0;
   st = 1'h1;
   run_wait(n);
   chk(n, 2 * `ARSC_SAMPLE_TICKS + 1);
   chk(ast, 1'h0);
   service;
   run_wait(n);
   chk(n, 2 * `ARSC_SAMPLE_TICKS - 1);
   service;
   stop_sweep;
   $display("undivided sweep test done");
end endtask
task t_halved; integer n; begin
   dv = 1'h1;
   su = 1'h1;
   oa = 1'h1;
   st = 1'h1;
   run_wait(n);
   chk(n >= 4 * `ARSC_SAMPLE_TICKS && n <= 4 * `ARSC_SAMPLE_TICKS + 1, 1'h1);
   chk(ast, 1'h1);
   service;
   run_wait(n);
   chk(flg, 1'h1);
   service;
   stop_sweep;
   $display("halved sweep test done");
end endtask
task t_source; integer n; begin
   dv = 1'h0;
   su = 1'h0;
   oa = 1'h0;
   st = 1'h1;
   run_wait(n);
   chk(n >= 4 * `ARSC_SAMPLE_TICKS && n <= 4 * `ARSC_SAMPLE_TICKS + 1, 1'h1);
   chk(ast, 1'h0);
   service;
   stop_sweep;
   $display("divided source test done");
end endtask
task t_race; begin
   dv = 1'h0;
   su = 1'h1;
   st = 1'h1;
   #(10 * 2 * `ARSC_SAMPLE_TICKS);
   clr = 1'h1;
   #10;
   clr = 1'h0;
   chk(flg, 1'h1);
   #10;
   service;
   stop_sweep;
   $display("set and clear race test done");
end endtask
task t_reset; begin
   dv = 1'h0;
   su = 1'h1;
   st = 1'h1;
   #150;
   rst_n = 1'h0;
   st = 1'h0;
   #100;
   rst_n = 1'h1;
   chk(bsy, 1'h0);
   chk(r0, `ARSC_RES_RST);
   chk(r1, `ARSC_RES_RST);
   chk(flg, 1'h0);
   #20;
   chk(bsy, 1'h0);
   chk(sel, 2'h0);
   $display("mid-run reset test done");
end endtask
initial begin
   #20000;
   mismatches = mismatches + 1;
   close_out;
end
initial begin
   #96;
   rst_n = 1'h1;
   t_undivided;
   t_halved;
   t_source;
   t_race;
   t_reset;
   t_undivided;
   close_out;
end
endmodule
